// ==== core/egecc_core.sv ====
/*
 * grouped ecc engine between the serial front end and the array.
 * assumes the front end gives byte reads and a collected write page,
 * and that the array answers a group read in the same cycle.
 */
// Overview of operation
// - correction hidden; bus timing never changes
// - check bits kept per four-byte group
// - group index is address bits two and up
// - single bad bit corrected on every read
// - lone byte write reprograms whole group
// - byte or page write starts programming
// - program after stop; busy refuses requests
// - page address wraps in low seven bits
`timescale 1ns/1ps
`default_nettype none
`include "egecc_params.svh"
module egecc_core
    import egecc_pkg::*;
#(
    parameter int TWR_CYC = `EGECC_TWR_CYC // programming wait in clock cycles
)
(
    input wire logic sys_clk_in,
    input wire logic resetn_in,
    // read port from the serial front end
    input wire logic rd_req_in,
    input wire egecc_addr_t rd_addr_in,
    output logic [7:0] rd_data_out,
    output logic rd_fixed_out,
    // write byte collection and stop strobe
    input wire logic wr_byte_in,
    input wire egecc_addr_t wr_addr_in,
    input wire logic [7:0] wr_data_in,
    input wire logic stop_in,
    output logic busy_out,
    // array group port
    output logic [`EGECC_ADDR_W-3:0] arr_grp_out,
    input wire egecc_cw_t arr_rdata_in,
    output logic arr_we_out,
    output var egecc_cw_t arr_wdata_out
);
    logic [7:0] page_buf [`EGECC_PAGE_BYTES]; // collected write data
    logic [`EGECC_PAGE_BYTES-1:0] page_hit; // bytes received this frame
    logic [`EGECC_ADDR_W-8:0] page_base; // page number of the frame
    logic [4:0] grp_idx; // group within the page
    egecc_state_t state;
    egecc_word_t merged; // group after merge
    logic [31:0] wr_cnt; // programming time counter
    egecc_word_t fix_word;
    logic fix_err;
    logic [`EGECC_CHK_W-1:0] mrg_chk;

    // the array group address: read side when idle, else write group
    logic [`EGECC_ADDR_W-3:0] next_grp;
    always_comb
    begin
        if (state == EG_IDLE)
            next_grp = rd_addr_in[`EGECC_ADDR_W-1:2];
        else
            next_grp = {page_base, grp_idx};
    end

    egecc_codec u_rd (
        .data_in(arr_rdata_in.data),
        .chk_in(arr_rdata_in.chk),
        .enc_out(),
        .fix_out(fix_word),
        .err_out(fix_err)
    );
    egecc_codec u_wr (
        .data_in(merged),
        .chk_in(`EGECC_CHK_W'(0)),
        .enc_out(mrg_chk),
        .fix_out(),
        .err_out()
    );

    // collect write bytes; wrap inside the page
    always_ff @(posedge sys_clk_in)
    begin
        if (!resetn_in)
        begin
            page_hit <= '0;
            page_base <= '0;
        end
        else if (state == EG_IDLE && wr_byte_in)
        begin
            page_buf[wr_addr_in[6:0]] <= wr_data_in;
            page_hit[wr_addr_in[6:0]] <= 1'b1;
            page_base <= wr_addr_in[`EGECC_ADDR_W-1:7];
        end
        else if (state == EG_WAIT && wr_cnt == 32'h0)
            page_hit <= '0;
    end

    // read path: corrected byte, same latency either way
    always_ff @(posedge sys_clk_in)
    begin
        if (!resetn_in)
        begin
            rd_data_out <= 8'h00;
            rd_fixed_out <= 1'b0;
        end
        else if (rd_req_in && state == EG_IDLE)
        begin
            rd_data_out <= fix_word[rd_addr_in[1:0]*8 +: 8];
            rd_fixed_out <= fix_err;
        end
    end

    // write sequencer: one group at a time, then the programming wait
    always_ff @(posedge sys_clk_in)
    begin
        if (!resetn_in)
        begin
            state <= EG_IDLE;
            grp_idx <= 5'h00;
            merged <= '0;
            wr_cnt <= 32'h0;
            busy_out <= 1'b0;
            arr_we_out <= 1'b0;
            arr_wdata_out <= '0;
            arr_grp_out <= '0;
        end
        else
        begin
            arr_grp_out <= next_grp;
            arr_we_out <= 1'b0;
            unique case (state)
                EG_IDLE:
                begin
                    if (stop_in && (|page_hit))
                    begin
                        state <= EG_RDGRP;
                        busy_out <= 1'b1;
                        grp_idx <= 5'h00;
                    end
                end
                EG_RDGRP:
                begin
                    if (|page_hit[grp_idx*4 +: 4])
                        state <= EG_MERGE;
                    else if (grp_idx == 5'h1f)
                    begin
                        state <= EG_WAIT;
                        wr_cnt <= TWR_CYC;
                    end
                    else
                        grp_idx <= grp_idx + 5'h01;
                end
                EG_MERGE:
                begin
                    // keep old corrected bytes, overlay new ones
                    for (int b = 0; b < 4; b++)
                    begin
                        if (page_hit[grp_idx*4 + b])
                            merged[b*8 +: 8] <= page_buf[grp_idx*4 + b];
                        else
                            merged[b*8 +: 8] <= fix_word[b*8 +: 8];
                    end
                    state <= EG_PROG;
                end
                EG_PROG:
                begin
                    arr_we_out <= 1'b1;
                    arr_wdata_out <= '{chk: mrg_chk, data: merged};
                    state <= EG_NEXT;
                end
                EG_NEXT:
                begin
                    if (grp_idx == 5'h1f)
                    begin
                        state <= EG_WAIT;
                        wr_cnt <= TWR_CYC;
                    end
                    else
                    begin
                        grp_idx <= grp_idx + 5'h01;
                        state <= EG_RDGRP;
                    end
                end
                EG_WAIT:
                begin
                    if (wr_cnt == 32'h0)
                    begin
                        state <= EG_IDLE;
                        busy_out <= 1'b0;
                    end
                    else
                        wr_cnt <= wr_cnt - 32'h1;
                end
            endcase
        end
    end

    // checks
    property p_busy_on_stop;
        @(posedge sys_clk_in) disable iff (!resetn_in)
        (state == EG_IDLE && stop_in && (|page_hit)) |=> busy_out;
    endproperty
    a_busy_on_stop: assert property (p_busy_on_stop) else $error("no busy after stop");
    property p_we_full;
        @(posedge sys_clk_in) disable iff (!resetn_in)
        arr_we_out |-> $past(state) == EG_PROG;
    endproperty
    a_we_full: assert property (p_we_full) else $error("array write outside program");
    property p_we_chk;
        @(posedge sys_clk_in) disable iff (!resetn_in)
        arr_we_out |-> (arr_wdata_out.chk == $past(mrg_chk));
    endproperty
    a_we_chk: assert property (p_we_chk) else $error("check bits stale");
    property p_busy_hold;
        @(posedge sys_clk_in) disable iff (!resetn_in)
        (state != EG_IDLE) |-> busy_out;
    endproperty
    a_busy_hold: assert property (p_busy_hold) else $error("busy dropped early");
    property p_rd_fix;
        @(posedge sys_clk_in) disable iff (!resetn_in)
        (rd_req_in && state == EG_IDLE) |=>
            rd_data_out == $past(fix_word[rd_addr_in[1:0]*8 +: 8]);
    endproperty
    a_rd_fix: assert property (p_rd_fix) else $error("read not corrected");
    property p_no_idle_we;
        @(posedge sys_clk_in) disable iff (!resetn_in)
        (state == EG_IDLE) |=> !arr_we_out;
    endproperty
    a_no_idle_we: assert property (p_no_idle_we) else $error("write while idle");
    property p_merge_prog;
        @(posedge sys_clk_in) disable iff (!resetn_in)
        (state == EG_MERGE) |=> ##1 arr_we_out;
    endproperty
    a_merge_prog: assert property (p_merge_prog) else $error("merge not programmed");
    property p_grp_addr;
        @(posedge sys_clk_in) disable iff (!resetn_in)
        (state == EG_IDLE) |=> arr_grp_out == $past(rd_addr_in[`EGECC_ADDR_W-1:2]);
    endproperty
    a_grp_addr: assert property (p_grp_addr) else $error("wrong group");
    property p_wrap;
        @(posedge sys_clk_in) disable iff (!resetn_in)
        (state == EG_IDLE && wr_byte_in) |=> page_hit[$past(wr_addr_in[6:0])];
    endproperty
    a_wrap: assert property (p_wrap) else $error("page byte lost");
    c_prog: cover property (@(posedge sys_clk_in) arr_we_out);
    c_fix: cover property (@(posedge sys_clk_in) rd_req_in && fix_err);
    c_done: cover property (@(posedge sys_clk_in) $fell(busy_out));
endmodule : egecc_core
`default_nettype wire

// ==== core/egecc_params.svh ====
/*
 * timing counts and geometry constants for the grouped ecc engine.
 * assumes a 20 mhz system clock and a 15-bit byte address space.
 */
`ifndef EGECC_PARAMS_SVH
`define EGECC_PARAMS_SVH
`define EGECC_ADDR_W 15
`define EGECC_GRP_BYTES 4
`define EGECC_CHK_W 7
`define EGECC_PAGE_BYTES 128
`define EGECC_CLK_NS 50
`define EGECC_TWR_MS 5
`define EGECC_TWR_CYC ((`EGECC_TWR_MS * 1000000) / `EGECC_CLK_NS)
// shortened programming wait used by the bench so a run stays short
`define EGECC_TWR_TB_CYC 200
// bench cycle ceiling: two programming waits plus reads, with margin
`define EGECC_TB_TIMEOUT 5000
`endif

// ==== core/egecc_pkg.sv ====
/*
 * types shared by the grouped ecc engine.
 * assumes the constants header is included first.
 */
`include "egecc_params.svh"
package egecc_pkg;
    typedef logic [`EGECC_ADDR_W-1:0] egecc_addr_t;
    typedef logic [`EGECC_GRP_BYTES*8-1:0] egecc_word_t;
    // one stored group: data word plus check bits
    typedef struct packed {
        logic [`EGECC_CHK_W-1:0] chk;
        egecc_word_t data;
    } egecc_cw_t;
    typedef enum logic [5:0] {
        EG_IDLE = 6'h01,
        EG_RDGRP = 6'h02,
        EG_MERGE = 6'h04,
        EG_PROG = 6'h08,
        EG_NEXT = 6'h10,
        EG_WAIT = 6'h20
    } egecc_state_t;
endpackage : egecc_pkg

// ==== core/egecc_codec.sv ====
/*
 * hamming secded-style codec for one 32-bit group (single-bit correct).
 * assumes purely combinational use by the engine.
 */
`timescale 1ns/1ps
`default_nettype none
`include "egecc_params.svh"
module egecc_codec
    import egecc_pkg::*;
(
    input wire egecc_word_t data_in,
    input wire logic [`EGECC_CHK_W-1:0] chk_in,
    output logic [`EGECC_CHK_W-1:0] enc_out,
    output var egecc_word_t fix_out,
    output logic err_out
);
    // position of data bit i in a 38-bit hamming frame (skip powers of two)
    function automatic logic [5:0] egecc_pos(input int i);
        int p;
        int n;
        p = 0;
        n = -1;
        for (int k = 1; k < 64; k++)
        begin
            if ((k & (k - 1)) != 0 && n < i)
            begin
                n = n + 1;
                p = k;
            end
        end
        return 6'(p);
    endfunction : egecc_pos

    logic [5:0] syn; // recomputed parity xor stored parity
    // encode: xor positions of set bits, overall parity in bit 6
    always_comb
    begin
        logic [5:0] acc;
        logic [5:0] acc2;
        acc = 6'h00;
        acc2 = 6'h00;
        for (int i = 0; i < 32; i++)
        begin
            if (data_in[i])
                acc = acc ^ egecc_pos(i);
        end
        enc_out = {^{acc, data_in}, acc};
        acc2 = acc ^ chk_in[5:0];
        syn = acc2;
        fix_out = data_in;
        for (int i = 0; i < 32; i++)
        begin
            if (acc2 == egecc_pos(i))
                fix_out[i] = ~data_in[i];
        end
        err_out = (syn != 6'h00);
    end
endmodule : egecc_codec
`default_nettype wire

// ==== verification/egecc_array_model.sv ====
/*
 * array model: one stored codeword per four-byte group.
 * assumes reads are combinational on the group address and that
 * writes land on the engine's one-cycle write pulse.
 */
`include "egecc_params.svh"
`timescale 1ns/1ps
`default_nettype none
module egecc_array_model
    import egecc_pkg::*;
(
    input wire logic clk_in,
    input wire logic [`EGECC_ADDR_W-3:0] grp_in,
    input wire logic we_in,
    input wire egecc_cw_t wdata_in,
    output var egecc_cw_t rdata_out,
    input wire logic flip_in,
    input wire logic [`EGECC_ADDR_W-3:0] flip_grp_in,
    input wire logic [5:0] flip_bit_in
);
    egecc_cw_t mem [0:(1<<(`EGECC_ADDR_W-2))-1]; // zero is a valid codeword
    assign rdata_out = mem[grp_in];
    // write pulse stores a group, flip models one upset cell
    always @(posedge clk_in)
    begin
        if (we_in)
            mem[grp_in] <= wdata_in;
        else if (flip_in)
            mem[flip_grp_in][flip_bit_in] <= ~mem[flip_grp_in][flip_bit_in];
    end
    initial
    begin
        foreach (mem[i]) mem[i] = '0;
    end
endmodule : egecc_array_model
`default_nettype wire

// ==== verification/testbench.sv ====
/*
 * self-checking bench for the grouped ecc engine.
 * assumes the array model above and a shortened programming time count.
 */
`include "egecc_params.svh"
`timescale 1ns/1ps
`default_nettype none
module testbench
    import egecc_pkg::*;
;
    logic sys_clk_in = 0, resetn_in = 0, rd_req = 0, wr_byte = 0, stop = 0, flip = 0;
    egecc_addr_t rd_addr = '0, wr_addr = '0;
    logic [7:0] wr_data = 8'h00, rd_data;
    logic [12:0] flip_grp = 13'h0000, arr_grp;
    logic [5:0] flip_bit = 6'h00;
    logic rd_fixed, busy, arr_we, req_d = 0;
    egecc_cw_t arr_rdata, arr_wdata;
    int fail_count = 0, check_count = 0, cycles = 0;
    int busy_cyc = 0; // cycles seen with busy high
    logic [15:0] seed = 16'hbe56; // lfsr state
    logic [7:0] e [0:7]; // expected bytes of groups 0x40 and 0x41
    logic [8:0] expq [$]; // notes of {fixed, byte}

    egecc_core #(.TWR_CYC(`EGECC_TWR_TB_CYC)) egecc_core_inst (.sys_clk_in(sys_clk_in),
        .resetn_in(resetn_in),
        .rd_req_in(rd_req), .rd_addr_in(rd_addr), .rd_data_out(rd_data),
        .rd_fixed_out(rd_fixed), .wr_byte_in(wr_byte), .wr_addr_in(wr_addr),
        .wr_data_in(wr_data), .stop_in(stop), .busy_out(busy), .arr_grp_out(arr_grp),
        .arr_rdata_in(arr_rdata), .arr_we_out(arr_we), .arr_wdata_out(arr_wdata));
    egecc_array_model egecc_array_model_inst (.clk_in(sys_clk_in), .grp_in(arr_grp),
        .we_in(arr_we), .wdata_in(arr_wdata), .rdata_out(arr_rdata), .flip_in(flip),
        .flip_grp_in(flip_grp), .flip_bit_in(flip_bit));

    always #25 sys_clk_in = ~sys_clk_in;
    // hang guard
    always @(posedge sys_clk_in)
    begin
        cycles++;
        if (cycles == `EGECC_TB_TIMEOUT)
        begin
            fail_count++;
            end_of_test();
        end
    end
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic tick();
        @(posedge sys_clk_in);
        #5;
    endtask : tick
    task automatic wr(input egecc_addr_t a, input logic [7:0] d);
        wr_addr = a;
        wr_data = d;
        wr_byte = 1;
        tick();
        wr_byte = 0;
        tick();
    endtask : wr
    // address leads the request by one cycle for the registered group port
    task automatic rd(input egecc_addr_t a, input logic [8:0] exp);
        rd_addr = a;
        tick();
        rd_req = 1;
        expq.push_back(exp);
        tick();
        rd_req = 0;
        tick();
    endtask : rd
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_of_test
    // watcher: compares the answer of each accepted read
    always
    begin
        @(posedge sys_clk_in);
        #1;
        if (req_d)
            check({rd_fixed, rd_data}, expq.pop_front());
        req_d = rd_req & ~busy;
    end
    initial
    begin
        repeat (6) tick();
        resetn_in = 1;
        tick();
        // two full groups of one page in a single frame, random bytes
        for (int i = 0; i < 8; i++)
        begin
            seed = lfsr(seed);
            e[i] = seed[7:0];
            wr(15'h0100 + 15'(i), e[i]);
        end
        check({8'h00, busy}, 9'h000);
        stop = 1;
        tick();
        stop = 0;
        tick();
        check({8'h00, busy}, 9'h001);
        // requests while programming are ignored
        rd_req = 1;
        wr_addr = 15'h0200;
        wr_data = 8'haa;
        wr_byte = 1;
        tick();
        rd_req = 0;
        wr_byte = 0;
        busy_cyc = 2;
        while (busy === 1'b1)
        begin
            busy_cyc++;
            tick();
        end
        check({8'h00, busy_cyc >= `EGECC_TWR_TB_CYC}, 9'h001);
        // nothing was collected while busy, so this stop starts nothing
        stop = 1;
        tick();
        stop = 0;
        tick();
        check({8'h00, busy}, 9'h000);
        $display("write cycle test done");
        // lone byte rewrite: the other three bytes of its group must survive
        seed = lfsr(seed);
        e[5] = seed[7:0];
        wr(15'h0105, e[5]);
        stop = 1;
        tick();
        stop = 0;
        tick();
        check({8'h00, busy}, 9'h001);
        while (busy === 1'b1)
            tick();
        for (int i = 0; i < 4; i++)
        begin
            rd(15'h0100 + 15'(i), {1'b0, e[i]});
            rd(15'h0104 + 15'(i), {1'b0, e[4+i]});
        end
        rd(15'h0200, 9'h000);
        $display("merge and refusal test done");
        // single upset in alternate groups, each corrected on read
        for (int k = 0; k < 6; k++)
        begin
            seed = lfsr(seed);
            flip_grp = k[0] ? 13'h0041 : 13'h0040;
            flip_bit = {1'b0, seed[4:0]};
            flip = 1;
            tick();
            flip = 0;
            for (int i = 0; i < 4; i++)
                rd((k[0] ? 15'h0104 : 15'h0100) + 15'(i), {1'b1, e[k[0]*4+i]});
            flip = 1;
            tick();
            flip = 0;
            tick();
        end
        $display("correction test done");
        tick();
        end_of_test();
    end
endmodule : testbench
`default_nettype wire
